//--- common/ptc_pkg.sv
// Shared constants for the paired timer control block.
`default_nettype none
package ptc_pkg;
  localparam int unsigned PTC_NUM_TMR = 4;
  localparam int unsigned PTC_AW      = 8;
  localparam int unsigned PTC_DW      = 32;
  localparam int unsigned PTC_PIN_W   = 9;
  localparam int unsigned PTC_DIV_W   = 8;
  // Register groups sit on 16-byte boundaries; one word per timer, except the status and mask words of the interrupt group.
  localparam logic [3:0] GRP_CON  = 4'h0;
  localparam logic [3:0] GRP_TMR  = 4'h1;
  localparam logic [3:0] GRP_PR   = 4'h2;
  localparam logic [3:0] GRP_IRQ  = 4'h3;
  localparam logic [1:0] IDX_STAT = 2'h0;
  localparam logic [1:0] IDX_MASK = 2'h1;
  // Control register fields.
  localparam int unsigned BIT_RUN    = 15;
  localparam int unsigned BIT_IDLE   = 13;
  localparam int unsigned BIT_GATE   = 6;
  localparam int unsigned BIT_DIV_HI = 5;
  localparam int unsigned BIT_DIV_LO = 4;
  localparam int unsigned BIT_JOIN   = 3;
  localparam int unsigned BIT_CS     = 1;
  localparam logic [15:0] MASK_EVEN = 16'hA07A;
  localparam logic [15:0] MASK_ODD  = 16'hA072;
  localparam logic [15:0] CON_RST   = 16'h0000;
  localparam logic [15:0] WORD_RST  = 16'h0000;
  // Prescale select codes and their terminal counts.
  localparam logic [1:0] DIV_SEL_1   = 2'h0;
  localparam logic [1:0] DIV_SEL_8   = 2'h1;
  localparam logic [1:0] DIV_SEL_64  = 2'h2;
  localparam logic [1:0] DIV_SEL_256 = 2'h3;
  localparam logic [7:0] DIV_TC_1    = 8'h00;
  localparam logic [7:0] DIV_TC_8    = 8'h07;
  localparam logic [7:0] DIV_TC_64   = 8'h3F;
  localparam logic [7:0] DIV_TC_256  = 8'hFF;
endpackage : ptc_pkg
`default_nettype wire

//--- rtl/ptc_sync.sv
// Two-stage synchroniser for asynchronous input pins.
`timescale 1ns/100ps
`default_nettype none
module ptc_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      q_ff    <= '0;
    end else begin
      meta_ff <= d;
      q_ff    <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule : ptc_sync
`default_nettype wire

//--- rtl/ptc_prescale.sv
// Input clock prescaler for one timer.
`timescale 1ns/100ps
`default_nettype none
module ptc_prescale (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clr,
  input  wire logic       tick_in,
  input  wire logic [1:0] div_sel,
  output var  logic       tick_out
);
  import ptc_pkg::*;

  logic [PTC_DIV_W-1:0] cnt_ff;
  logic [PTC_DIV_W-1:0] nxt_cnt;
  logic [PTC_DIV_W-1:0] tc;

  always_comb begin
    case (div_sel)
      DIV_SEL_1:   tc = DIV_TC_1;
      DIV_SEL_8:   tc = DIV_TC_8;
      DIV_SEL_64:  tc = DIV_TC_64;
      DIV_SEL_256: tc = DIV_TC_256;
      default:     tc = DIV_TC_1;
    endcase
    tick_out = tick_in & (cnt_ff >= tc);
    nxt_cnt  = cnt_ff;
    if (clr) begin
      nxt_cnt = '0;
    end else if (tick_in) begin
      nxt_cnt = (cnt_ff >= tc) ? '0 : PTC_DIV_W'(cnt_ff + 8'h01);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule : ptc_prescale
`default_nettype wire

//--- rtl/ptc_top.sv
// Two pairs of 16-bit timers, joinable into 32-bit timers, with an APB slave.
//
// Notes on behaviour
// - Even timer run bit starts the joined pair, or its own timer; clear stops.
// - Halt-in-idle bit stops the timer during idle mode; clear keeps counting.
// - With internal clock, gate bit counts only while gate input is high.
// - Prescale codes 00, 01, 10, 11 divide by 1, 8, 64, 256.
// - First pair join bit makes one 32-bit timer; clear gives two timers.
// - Second pair join bit does the same for the second pair.
// - Clock source bit selects rising edges of the pin, else internal clock.
// - Every timer counts the internal clock at oscillator over two.
// - When first pair is joined, odd timer control bits other than halt-in-idle have no effect.
// - When second pair is joined, odd timer control bits other than halt-in-idle have no effect.
// - Unimplemented control register bits read as zero.
// - Joined count has the even timer as low word, odd as high word.
// - Joined pair signals its match through the odd timer's flag.
// - Joined pair flags when the 32-bit count equals the 32-bit period.
`timescale 1ns/100ps
`default_nettype none
module ptc_top (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [ptc_pkg::PTC_AW-1:0] paddr,
  input  wire logic [ptc_pkg::PTC_DW-1:0] pwdata,
  output var  logic [ptc_pkg::PTC_DW-1:0] prdata,
  output var  logic                      pready,
  output var  logic                      pslverr,
  input  wire logic                      pair_a_ext_clock_pin,
  input  wire logic                      pair_a_high_ext_clock_pin,
  input  wire logic                      pair_b_ext_clock_pin,
  input  wire logic                      pair_b_high_ext_clock_pin,
  input  wire logic [3:0]                timer_gate_pin,
  input  wire logic                      idle_mode,
  output var  logic                      irq
);
  import ptc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge detection.

  logic [PTC_PIN_W-1:0] pin_q;
  logic [3:0]           ext_q;
  logic [3:0]           gate_q;
  logic                 idle_q;
  logic [3:0]           ext_d_ff;
  logic [3:0]           ext_rise;

  ptc_sync #(.W(PTC_PIN_W)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({idle_mode, timer_gate_pin, pair_b_high_ext_clock_pin,
               pair_b_ext_clock_pin, pair_a_high_ext_clock_pin, pair_a_ext_clock_pin}),
    .q       (pin_q)
  );

  assign ext_q    = pin_q[3:0];
  assign gate_q   = pin_q[7:4];
  assign idle_q   = pin_q[8];
  assign ext_rise = ext_q & ~ext_d_ff;

  //////////////////////////////////////////////////////////////////////////////
  // State.

  logic [3:0][15:0] con_ff;
  logic [3:0][15:0] nxt_con;
  logic [3:0][15:0] tmr_ff;
  logic [3:0][15:0] nxt_tmr;
  logic [3:0][15:0] pr_ff;
  logic [3:0][15:0] nxt_pr;
  logic [3:0]       stat_ff;
  logic [3:0]       nxt_stat;
  logic [3:0]       mask_ff;
  logic [3:0]       nxt_mask;
  logic             irq_ff;
  logic             nxt_irq;
  logic             pready_ff;
  logic             nxt_pready;
  logic             pslverr_ff;
  logic             nxt_pslverr;
  logic [31:0]      prdata_ff;
  logic [31:0]      nxt_prdata;
  logic [1:0]       pair_join;
  logic [3:0]       run;
  logic [3:0]       raw_tick;
  logic [3:0]       tick;
  logic [3:0]       hit;
  logic [3:0][1:0]  eff_div;
  logic [3:0]       grp;
  logic [1:0]       idx;
  logic             wr_en;

  assign grp       = paddr[7:4];
  assign idx       = paddr[3:2];
  assign wr_en     = psel & penable & pready_ff & pwrite;
  assign pair_join = {con_ff[2][BIT_JOIN], con_ff[0][BIT_JOIN]};

  //////////////////////////////////////////////////////////////////////////////
  // Effective control per timer; an odd timer of a joined pair follows the even.

  always_comb begin : ctl_comb
    int   src;
    logic stop_idle;
    src       = 0;
    stop_idle = 1'b0;
    for (int i = 0; i < PTC_NUM_TMR; i++) begin
      src         = ((i % 2) == 1 && pair_join[i / 2]) ? i - 1 : i;
      stop_idle   = con_ff[i][BIT_IDLE] | (pair_join[i / 2] & con_ff[i ^ 1][BIT_IDLE]);
      run[i]      = con_ff[src][BIT_RUN] & ~(idle_q & stop_idle);
      eff_div[i]  = con_ff[src][BIT_DIV_HI:BIT_DIV_LO];
      // The internal clock is pclk for every timer, oscillator over two.
      raw_tick[i] = run[i] & (con_ff[src][BIT_CS] ? ext_rise[src]
                                                  : (~con_ff[src][BIT_GATE] | gate_q[src]));
    end
  end

  for (genvar g = 0; g < PTC_NUM_TMR; g++) begin : g_div
    ptc_prescale u_div (
      .pclk     (pclk),
      .presetn  (presetn),
      .clr      (~run[g]),
      .tick_in  (raw_tick[g]),
      .div_sel  (eff_div[g]),
      .tick_out (tick[g])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counters and period match.

  always_comb begin : cnt_comb
    logic [31:0] cnt32;
    logic [31:0] pr32;
    cnt32   = '0;
    pr32    = '0;
    nxt_tmr = tmr_ff;
    hit     = '0;
    for (int p = 0; p < 2; p++) begin
      cnt32 = {tmr_ff[2 * p + 1], tmr_ff[2 * p]};
      pr32  = {pr_ff[2 * p + 1], pr_ff[2 * p]};
      if (pair_join[p]) begin
        if (tick[2 * p]) begin
          if (cnt32 == pr32) begin
            {nxt_tmr[2 * p + 1], nxt_tmr[2 * p]} = '0;
            hit[2 * p + 1] = 1'b1;
          end else begin
            {nxt_tmr[2 * p + 1], nxt_tmr[2 * p]} = 32'(cnt32 + 32'h0000_0001);
          end
        end
      end else begin
        for (int h = 0; h < 2; h++) begin
          if (tick[2 * p + h]) begin
            if (tmr_ff[2 * p + h] == pr_ff[2 * p + h]) begin
              nxt_tmr[2 * p + h] = '0;
              hit[2 * p + h]     = 1'b1;
            end else begin
              nxt_tmr[2 * p + h] = 16'(tmr_ff[2 * p + h] + 16'h0001);
            end
          end
        end
      end
    end
    if (wr_en && grp == GRP_TMR) begin
      nxt_tmr[idx] = pwdata[15:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB register file and interrupt.

  always_comb begin : bus_comb
    logic [3:0] w1c;
    w1c         = '0;
    nxt_con     = con_ff;
    nxt_pr      = pr_ff;
    nxt_mask    = mask_ff;
    nxt_prdata  = prdata_ff;
    nxt_pready  = psel & ~penable;
    nxt_pslverr = 1'b0;
    if (wr_en) begin
      case (grp)
        GRP_CON: nxt_con[idx] = pwdata[15:0] & (idx[0] ? MASK_ODD : MASK_EVEN);
        GRP_PR:  nxt_pr[idx]  = pwdata[15:0];
        GRP_IRQ: begin
          if (idx == IDX_STAT) begin
            w1c = pwdata[3:0];
          end
          if (idx == IDX_MASK) begin
            nxt_mask = pwdata[3:0];
          end
        end
        default: nxt_con = con_ff;
      endcase
    end
    // A match in the same cycle as its clear keeps the flag set.
    nxt_stat = (stat_ff & ~w1c) | hit;
    nxt_irq  = |(nxt_stat & nxt_mask);
    if (psel && !penable) begin
      nxt_prdata = '0;
      case (grp)
        GRP_CON: nxt_prdata[15:0] = con_ff[idx];
        GRP_TMR: nxt_prdata[15:0] = tmr_ff[idx];
        GRP_PR:  nxt_prdata[15:0] = pr_ff[idx];
        GRP_IRQ: begin
          if (idx == IDX_STAT) begin
            nxt_prdata[3:0] = stat_ff;
          end else if (idx == IDX_MASK) begin
            nxt_prdata[3:0] = mask_ff;
          end else begin
            nxt_pslverr = 1'b1;
          end
        end
        default: nxt_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      con_ff     <= {PTC_NUM_TMR{CON_RST}};
      tmr_ff     <= {PTC_NUM_TMR{WORD_RST}};
      pr_ff      <= {PTC_NUM_TMR{WORD_RST}};
      stat_ff    <= '0;
      mask_ff    <= '0;
      irq_ff     <= 1'b0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
      ext_d_ff   <= '0;
    end else begin
      con_ff     <= nxt_con;
      tmr_ff     <= nxt_tmr;
      pr_ff      <= nxt_pr;
      stat_ff    <= nxt_stat;
      mask_ff    <= nxt_mask;
      irq_ff     <= nxt_irq;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
      ext_d_ff   <= ext_q;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq     = irq_ff;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions.

  logic        wr_tmr0;
  logic        wr_pair0;
  logic [31:0] cnt32a;
  logic [31:0] pr32a;

  assign wr_tmr0  = wr_en && grp == GRP_TMR && idx == 2'h0;
  assign wr_pair0 = wr_en && grp == GRP_TMR && !idx[1];
  assign cnt32a   = {tmr_ff[1], tmr_ff[0]};
  assign pr32a    = {pr_ff[1], pr_ff[0]};

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_join_step;
    pair_join[0] && tick[0] && !wr_pair0 && cnt32a != pr32a;
  endsequence

  sequence s_join_match;
    pair_join[0] && tick[0] && !wr_pair0 && cnt32a == pr32a;
  endsequence

  property p_stop_hold;
    !con_ff[0][BIT_RUN] && !wr_tmr0 |=> tmr_ff[0] == $past(tmr_ff[0]);
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("Stopped timer changed its count.");

  property p_idle_halt;
    idle_q && con_ff[0][BIT_IDLE] && !wr_tmr0 |=> $stable(tmr_ff[0]);
  endproperty
  a_idle_halt: assert property (p_idle_halt)
    else $error("Timer counted in idle with halt set.");

  property p_gate_block;
    con_ff[0][BIT_GATE] && !con_ff[0][BIT_CS] && !gate_q[0] |-> !raw_tick[0];
  endproperty
  a_gate_block: assert property (p_gate_block)
    else $error("Gated timer ticked with gate low.");

  property p_div_one;
    eff_div[0] == DIV_SEL_1 |-> tick[0] == raw_tick[0];
  endproperty
  a_div_one: assert property (p_div_one)
    else $error("Divide by one did not pass every tick.");

  property p_ext_only;
    con_ff[0][BIT_CS] && !ext_rise[0] |-> !raw_tick[0];
  endproperty
  a_ext_only: assert property (p_ext_only)
    else $error("External clocked timer ticked without pin edge.");

  property p_join_inc;
    s_join_step |=> {tmr_ff[1], tmr_ff[0]} == $past(cnt32a) + 32'h0000_0001;
  endproperty
  a_join_inc: assert property (p_join_inc)
    else $error("Joined count did not step as one word.");

  property p_join_wrap;
    s_join_match |=> stat_ff[1] && cnt32a == 32'h0000_0000;
  endproperty
  a_join_wrap: assert property (p_join_wrap)
    else $error("Joined match did not wrap and flag the odd timer.");

  property p_odd_follow_a;
    pair_join[0] |-> raw_tick[1] == raw_tick[0];
  endproperty
  a_odd_follow_a: assert property (p_odd_follow_a)
    else $error("Joined odd timer did not follow even control.");

  property p_odd_follow_b;
    pair_join[1] |-> raw_tick[3] == raw_tick[2];
  endproperty
  a_odd_follow_b: assert property (p_odd_follow_b)
    else $error("Joined odd timer did not follow even control.");
endmodule : ptc_top
`default_nettype wire

//--- sim/ptc_top_bench.sv
// Self-checking testbench for the paired timer control block.
`timescale 1ns/100ps
`default_nettype none
module ptc_top_bench;
  import ptc_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        idle_mode;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        err;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [3:0]  ext_pin;
  logic [3:0]  gate_pin;
  int          errors;
  int          checks_done;
  int          div_n[4] = '{1, 8, 64, 256};
  logic [15:0] con_model[4];

  ptc_top DUT (
    .pclk                      (pclk),
    .presetn                   (presetn),
    .psel                      (psel),
    .penable                   (penable),
    .pwrite                    (pwrite),
    .paddr                     (paddr),
    .pwdata                    (pwdata),
    .prdata                    (prdata),
    .pready                    (pready),
    .pslverr                   (pslverr),
    .pair_a_ext_clock_pin      (ext_pin[0]),
    .pair_a_high_ext_clock_pin (ext_pin[1]),
    .pair_b_ext_clock_pin      (ext_pin[2]),
    .pair_b_high_ext_clock_pin (ext_pin[3]),
    .timer_gate_pin            (gate_pin),
    .idle_mode                 (idle_mode),
    .irq                       (irq)
  );

  //////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    #(5_000_000);
    errors++;
    finish_test();
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // One APB transfer; entered just after a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    check({31'b0, pready}, 32'h0000_0001, "ready");
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a[7:4] == GRP_CON) begin
      con_model[a[3:2]] = d[15:0] & (a[2] ? MASK_ODD : MASK_EVEN);
    end
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp, what);
  endtask : rdchk

  // Runs timer t with the given control word for k cycles and checks its count range.
  task automatic measure(input int t, input logic [31:0] con, input int k, input int lo,
                         input int hi, input bit pulse, input string what);
    int c;
    wr(8'(16 + 4 * t), 32'h0000_0000);
    wr(8'(4 * t), con);
    for (c = 0; c < k; c++) begin
      @(posedge pclk);
      if (pulse && c < k - 8) begin
        ext_pin[t] <= ~ext_pin[t];
      end
    end
    wr(8'(4 * t), 32'h0000_0000);
    apb(1'b0, 8'(16 + 4 * t), 32'h0000_0000);
    check(32'(rd >= lo && rd <= hi), 32'h0000_0001, what);
  endtask : measure

  //////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    int          e;
    int          o;
    int          n;
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0000_0000;
    idle_mode = 1'b0;
    ext_pin   = 4'h0;
    gate_pin  = 4'h0;
    con_model = '{default: 16'h0000};
    void'($urandom(82022));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      rdchk(8'(4 * i), 32'h0000_0000, "control reset");
      d = $urandom() & 32'h0000_7FFF;
      wr(8'(4 * i), d);
      rdchk(8'(4 * i), {16'h0000, con_model[i]}, "readback");
      wr(8'(4 * i), 32'h0000_0000);
      wr(8'(32 + 4 * i), 32'h0000_FFFF);
      rdchk(8'(32 + 4 * i), 32'h0000_FFFF, "period readback");
    end
    foreach (div_n[t]) begin
      measure(t, 32'h0000_8000 | (t << 4), div_n[t] * 12, 12, (div_n[t] * 12 + 6) / div_n[t],
              1'b0, "prescaled count");
      measure(t, 32'h0000_8042, 28, 10, 10, 1'b1, "pin edges");
    end
    measure(0, 32'h0000_8040, 30, 0, 0, 1'b0, "gate closed");
    gate_pin <= 4'h1;
    measure(0, 32'h0000_8040, 30, 30, 40, 1'b0, "gate open");
    idle_mode <= 1'b1;
    measure(2, 32'h0000_A000, 30, 0, 0, 1'b0, "halted in idle");
    measure(2, 32'h0000_8000, 30, 30, 40, 1'b0, "runs in idle");
    idle_mode <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      e = 2 * p;
      o = e + 1;
      wr(8'h34, (p == 0) ? 32'h0000_000F : 32'h0000_0000);
      wr(8'(16 + 4 * e), 32'h0000_FFF0);
      wr(8'(16 + 4 * o), 32'h0000_0000);
      wr(8'(32 + 4 * e), 32'h0000_0100);
      wr(8'(32 + 4 * o), 32'h0000_0001);
      wr(8'(4 * o), 32'h0000_8032);
      wr(8'(4 * e), 32'h0000_8008);
      repeat (40) @(posedge pclk);
      wr(8'(4 * e), 32'h0000_0008);
      rdchk(8'(16 + 4 * o), 32'h0000_0001, "high word carry");
      apb(1'b0, 8'(16 + 4 * e), 32'h0000_0000);
      check(32'(rd >= 20 && rd <= 40), 32'h0000_0001, "low word");
      check({31'b0, irq}, 32'h0000_0000, "no early flag");
      wr(8'(4 * e), 32'h0000_8008);
      n = 0;
      do begin
        apb(1'b0, 8'h30, 32'h0000_0000);
        n++;
      end while (rd[o] !== 1'b1 && n < 200);
      check(rd, 32'(1 << o), "joined flag");
      check({31'b0, irq}, 32'(p == 0), "masked irq");
      wr(8'(4 * e), 32'h0000_0008);
      rdchk(8'(16 + 4 * o), 32'h0000_0000, "wrapped high word");
      wr(8'h34, 32'h0000_000F);
      check({31'b0, irq}, 32'h0000_0001, "irq raised");
      wr(8'h30, 32'(1 << o));
      rdchk(8'h30, 32'h0000_0000, "status cleared");
      check({31'b0, irq}, 32'h0000_0000, "irq cleared");
      wr(8'(4 * e), 32'h0000_0000);
      wr(8'(4 * o), 32'h0000_0000);
    end
    idle_mode <= 1'b1;
    wr(8'h04, 32'h0000_2000);
    wr(8'h10, 32'h0000_0000);
    wr(8'h00, 32'h0000_8008);
    repeat (20) @(posedge pclk);
    rdchk(8'h10, 32'h0000_0000, "joined halted by odd bit");
    wr(8'h04, 32'h0000_0000);
    repeat (20) @(posedge pclk);
    apb(1'b0, 8'h10, 32'h0000_0000);
    check(32'(rd >= 20 && rd <= 40), 32'h0000_0001, "joined runs in idle");
    wr(8'h00, 32'h0000_0000);
    idle_mode <= 1'b0;
    foreach (div_n[i]) begin
      wr(8'(56 + 8 * (i % 2)), 32'h0000_FFFF);
      rdchk(8'(56 + 8 * (i % 2)), 32'h0000_0000, "unmapped data");
      check({31'b0, err}, 32'h0000_0001, "unmapped error");
    end
    finish_test();
  end
endmodule : ptc_top_bench
`default_nettype wire
